// ---- hdl/keypad_gpio_ports.sv ----
// Nibble-wide general-purpose ports with their register file controls
//
// Operation
// - Key return port read-only at 70H bank 0
// - Low key, port B, C or D input pin releases standby
// - Port B per-bit direction at 26H
// - Pull-up ports: input pulls up, output open-drain
// - Output-mode bits read back the latch
// - Port B data at 71H bank 0
// - Port B inputs after reset
// - Ports C, D group direction bits 2, 3
// - Ports C, D data at 72H, 73H
// - Ports C, D reset to driving low
// - Port E direction 27H, data 6FH
// - Port E pull-ups 17H, kept in output
// - Port E inputs after reset
// - Single-bit port direction fixed by parameter
// - Single-bit port never releases standby
// - Single-bit port undriven after reset
// - 00H-3FH control, 40H-7FH data memory
// - Read copies to window, write copies from
// - Unused control nibbles: read as RD_UNUSED (0), write ignored
// - Writes to read-only registers ignored
// - Input-to-output switch drives latch at once
`timescale 1ns/1ps

module keypad_gpio_ports
  import keypad_gpio_pkg::*;
#(
  parameter int SINGLE_BIT_OUTPUT = 0     // 1 = single-bit port is output
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core access request (register file or data memory)
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic acc_rf,
  input wire logic acc_bank,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [NIB_W-1:0] acc_wdata,
  // Core access answer
  output logic [NIB_W-1:0] rd_data,
  output logic rd_valid,
  output logic mem_fwd,
  // Standby control
  input wire logic standby,
  output logic wake,
  // Key return input port
  input wire logic [NIB_W-1:0] key_pin_in,
  // Bit direction port B
  input wire logic [NIB_W-1:0] b_pin_in,
  output logic [NIB_W-1:0] b_pin_out,
  output logic [NIB_W-1:0] b_pin_oe_b,
  output logic [NIB_W-1:0] b_pullup_en,
  // Group port C
  input wire logic [NIB_W-1:0] c_pin_in,
  output logic [NIB_W-1:0] c_pin_out,
  output logic [NIB_W-1:0] c_pin_oe_b,
  output logic [NIB_W-1:0] c_pullup_en,
  // Group port D
  input wire logic [NIB_W-1:0] d_pin_in,
  output logic [NIB_W-1:0] d_pin_out,
  output logic [NIB_W-1:0] d_pin_oe_b,
  output logic [NIB_W-1:0] d_pullup_en,
  // Push-pull port E
  input wire logic [NIB_W-1:0] e_pin_in,
  output logic [NIB_W-1:0] e_pin_out,
  output logic [NIB_W-1:0] e_pin_oe_b,
  output logic [NIB_W-1:0] e_pullup_en,
  // Single-bit port
  input wire logic sb_pin_in,
  output logic sb_pin_out,
  output logic sb_pin_oe_b
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Only an input or an output configuration exists
  if (SINGLE_BIT_OUTPUT != 0 && SINGLE_BIT_OUTPUT != 1) begin : g_bad_cfg
    $error("SINGLE_BIT_OUTPUT must be 0 or 1");
  end

  // Fixed direction of the single-bit port as a one-bit constant
  localparam logic SB_OUT = (SINGLE_BIT_OUTPUT == 1);

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    // Two-stage synchronisers for every input pin
    logic [3:0] key_s1;
    logic [3:0] key_s2;
    logic [3:0] b_s1;
    logic [3:0] b_s2;
    logic [3:0] c_s1;
    logic [3:0] c_s2;
    logic [3:0] d_s1;
    logic [3:0] d_s2;
    logic [3:0] e_s1;
    logic [3:0] e_s2;
    logic sb_s1;
    logic sb_s2;
    // Control registers
    logic [3:0] b_dir;       // Port B direction, 1 = output
    logic [3:0] e_dir;       // Port E direction, 1 = output
    logic [3:0] e_pu;        // Port E pull-up enables
    logic grp_c_out;         // Port C group direction
    logic grp_d_out;         // Port D group direction
    // Output latches
    logic [3:0] b_lat;
    logic [3:0] c_lat;
    logic [3:0] d_lat;
    logic [3:0] e_lat;
    logic sb_lat;
    // Answer to the core
    logic [3:0] rd_data;
    logic rd_valid;
    logic mem_fwd;
    logic wake;
    // Registered pin drive
    logic od_level;          // Level driven by every open-drain pin
    logic [3:0] b_oe_b;
    logic [3:0] b_pu;
    logic [3:0] c_oe_b;
    logic [3:0] c_pu;
    logic [3:0] d_oe_b;
    logic [3:0] d_pu;
    logic [3:0] e_out;
    logic [3:0] e_oe_b;
    logic [3:0] e_pu_out;
    logic sb_oe_b;
  } state_t;

  // Value of the whole state after reset
  localparam state_t ST_RESET = '{
    key_s1: SYNC_IDLE, key_s2: SYNC_IDLE,
    b_s1: SYNC_IDLE, b_s2: SYNC_IDLE,
    c_s1: RST_LATCH, c_s2: RST_LATCH,
    d_s1: RST_LATCH, d_s2: RST_LATCH,
    e_s1: SYNC_IDLE, e_s2: SYNC_IDLE,
    sb_s1: 1'b1, sb_s2: 1'b1,
    b_dir: RST_B_DIR, e_dir: RST_E_DIR, e_pu: RST_E_PULLUP,
    grp_c_out: RST_GRP_OUT, grp_d_out: RST_GRP_OUT,
    b_lat: RST_LATCH, c_lat: RST_LATCH, d_lat: RST_LATCH,
    e_lat: RST_LATCH, sb_lat: RST_SB_LATCH,
    rd_data: RD_UNUSED, rd_valid: 1'b0, mem_fwd: 1'b0, wake: 1'b0,
    od_level: 1'b0,
    b_oe_b: 4'hf, b_pu: 4'hf,
    c_oe_b: 4'h0, c_pu: 4'h0,
    d_oe_b: 4'h0, d_pu: 4'h0,
    e_out: RST_LATCH, e_oe_b: 4'hf, e_pu_out: RST_E_PULLUP,
    sb_oe_b: 1'b1
  };

  state_t st_r;              // Registered state
  state_t st_nxt;            // Next state

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Decodes core accesses, updates latches and builds pin drive
  always_comb begin
    logic is_ctrl;
    logic wr;
    logic [3:0] b_rd;
    logic [3:0] c_rd;
    logic [3:0] d_rd;
    logic [3:0] e_rd;
    logic sb_rd;
    logic [3:0] wake_lo;
    st_nxt = st_r;
    // Synchronisers: first stage feeds only the second
    st_nxt.key_s1 = key_pin_in;
    st_nxt.key_s2 = st_r.key_s1;
    st_nxt.b_s1 = b_pin_in;
    st_nxt.b_s2 = st_r.b_s1;
    st_nxt.c_s1 = c_pin_in;
    st_nxt.c_s2 = st_r.c_s1;
    st_nxt.d_s1 = d_pin_in;
    st_nxt.d_s2 = st_r.d_s1;
    st_nxt.e_s1 = e_pin_in;
    st_nxt.e_s2 = st_r.e_s1;
    st_nxt.sb_s1 = sb_pin_in;
    st_nxt.sb_s2 = st_r.sb_s1;
    // Answer strobes last one cycle
    st_nxt.rd_valid = 1'b0;
    st_nxt.mem_fwd = 1'b0;
    // Control space is bank independent
    is_ctrl = acc_rf && (acc_addr <= RF_CTRL_LAST);
    // A write wins when both strobes are raised
    wr = acc_wr;

    // Read values: latch in output mode, pin in input mode
    b_rd = (st_r.b_dir & st_r.b_lat) | (~st_r.b_dir & st_r.b_s2);
    c_rd = st_r.grp_c_out ? st_r.c_lat : st_r.c_s2;
    d_rd = st_r.grp_d_out ? st_r.d_lat : st_r.d_s2;
    e_rd = (st_r.e_dir & st_r.e_lat) | (~st_r.e_dir & st_r.e_s2);
    sb_rd = SB_OUT ? st_r.sb_lat : st_r.sb_s2;

    // Write path
    if (wr) begin
      if (is_ctrl) begin
        case (acc_addr)
          // Control registers take the window value
          ADDR_E_PULLUP: begin
            st_nxt.e_pu = acc_wdata;
          end
          ADDR_B_DIR: begin
            st_nxt.b_dir = acc_wdata;
          end
          ADDR_E_DIR: begin
            st_nxt.e_dir = acc_wdata;
          end
          ADDR_GRP_DIR: begin
            st_nxt.grp_c_out = acc_wdata[GRP_C_BIT];
            st_nxt.grp_d_out = acc_wdata[GRP_D_BIT];
          end
          // Unused nibbles keep nothing
          default: begin
          end
        endcase
      end else if (acc_bank == BANK0) begin
        case (acc_addr)
          ADDR_E_DATA: begin
            st_nxt.e_lat = acc_wdata;
          end
          // Input-only port ignores writes
          ADDR_KEY_DATA: begin
          end
          ADDR_B_DATA: begin
            st_nxt.b_lat = acc_wdata;
          end
          ADDR_C_DATA: begin
            st_nxt.c_lat = acc_wdata;
          end
          ADDR_D_DATA: begin
            st_nxt.d_lat = acc_wdata;
          end
          // Anything else is general data memory
          default: begin
            st_nxt.mem_fwd = 1'b1;
          end
        endcase
      end else if (acc_addr == ADDR_SB_DATA) begin
        // Single-bit latch, bit 0 of the nibble
        st_nxt.sb_lat = acc_wdata[0];
      end else begin
        st_nxt.mem_fwd = 1'b1;
      end
    // Read path
    end else if (acc_rd) begin
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_data = RD_UNUSED;
      if (is_ctrl) begin
        case (acc_addr)
          ADDR_E_PULLUP: begin
            st_nxt.rd_data = st_r.e_pu;
          end
          ADDR_B_DIR: begin
            st_nxt.rd_data = st_r.b_dir;
          end
          ADDR_E_DIR: begin
            st_nxt.rd_data = st_r.e_dir;
          end
          ADDR_GRP_DIR: begin
            st_nxt.rd_data[GRP_C_BIT] = st_r.grp_c_out;
            st_nxt.rd_data[GRP_D_BIT] = st_r.grp_d_out;
          end
          // Unused nibbles answer a fixed filler
          default: begin
            st_nxt.rd_data = RD_UNUSED;
          end
        endcase
      end else if (acc_bank == BANK0) begin
        case (acc_addr)
          ADDR_E_DATA: begin
            st_nxt.rd_data = e_rd;
          end
          ADDR_KEY_DATA: begin
            st_nxt.rd_data = st_r.key_s2;
          end
          ADDR_B_DATA: begin
            st_nxt.rd_data = b_rd;
          end
          ADDR_C_DATA: begin
            st_nxt.rd_data = c_rd;
          end
          ADDR_D_DATA: begin
            st_nxt.rd_data = d_rd;
          end
          // Not ours: hand over to data memory
          default: begin
            st_nxt.rd_valid = 1'b0;
            st_nxt.mem_fwd = 1'b1;
          end
        endcase
      end else if (acc_addr == ADDR_SB_DATA) begin
        st_nxt.rd_data = {3'h0, sb_rd};
      end else begin
        st_nxt.rd_valid = 1'b0;
        st_nxt.mem_fwd = 1'b1;
      end
    end

    // Open-drain pins only ever pull low
    st_nxt.od_level = 1'b0;
    // Port B: drive low for output bits with latch 0, else release
    st_nxt.b_oe_b = ~(st_nxt.b_dir & ~st_nxt.b_lat);
    st_nxt.b_pu = ~st_nxt.b_dir;
    // Ports C and D follow their group direction
    st_nxt.c_oe_b = {4{~st_nxt.grp_c_out}} | st_nxt.c_lat;
    st_nxt.c_pu = {4{~st_nxt.grp_c_out}};
    st_nxt.d_oe_b = {4{~st_nxt.grp_d_out}} | st_nxt.d_lat;
    st_nxt.d_pu = {4{~st_nxt.grp_d_out}};
    // Port E: push-pull, pull-up independent of direction
    st_nxt.e_out = st_nxt.e_lat;
    st_nxt.e_oe_b = ~st_nxt.e_dir;
    st_nxt.e_pu_out = st_nxt.e_pu;
    // Single-bit port: open drain only when built as output
    st_nxt.sb_oe_b = ~(SB_OUT & ~st_nxt.sb_lat);

    // Standby release on any low key, port B, C or D input-mode line
    wake_lo = ~st_r.key_s2;
    wake_lo = wake_lo | (~st_r.b_dir & ~st_r.b_s2);
    wake_lo = wake_lo | ({4{~st_r.grp_c_out}} & ~st_r.c_s2);
    wake_lo = wake_lo | ({4{~st_r.grp_d_out}} & ~st_r.d_s2);
    // Single-bit port deliberately left out
    st_nxt.wake = standby && (|wake_lo);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous active-low reset loads the reset constant
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;
  assign mem_fwd = st_r.mem_fwd;
  assign wake = st_r.wake;
  assign b_pin_out = {4{st_r.od_level}};
  assign b_pin_oe_b = st_r.b_oe_b;
  assign b_pullup_en = st_r.b_pu;
  assign c_pin_out = {4{st_r.od_level}};
  assign c_pin_oe_b = st_r.c_oe_b;
  assign c_pullup_en = st_r.c_pu;
  assign d_pin_out = {4{st_r.od_level}};
  assign d_pin_oe_b = st_r.d_oe_b;
  assign d_pullup_en = st_r.d_pu;
  assign e_pin_out = st_r.e_out;
  assign e_pin_oe_b = st_r.e_oe_b;
  assign e_pullup_en = st_r.e_pu_out;
  assign sb_pin_out = st_r.od_level;
  assign sb_pin_oe_b = st_r.sb_oe_b;

endmodule : keypad_gpio_ports

// ---- hdl/keypad_gpio_pkg.sv ----
// Constants shared by the keypad nibble port block
package keypad_gpio_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;                 // Every port register is a nibble
  localparam int ADDR_W = 7;                // Register file / data address

  // ----------------------------------------------------------------
  // Register file space split
  // ----------------------------------------------------------------
  localparam logic [6:0] RF_CTRL_LAST = 7'h3f;  // 00H-3FH control space

  // ----------------------------------------------------------------
  // Control register offsets (bank independent)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_E_PULLUP = 7'h17;   // Port E pull-up enable
  localparam logic [6:0] ADDR_B_DIR = 7'h26;      // Port B bit direction
  localparam logic [6:0] ADDR_E_DIR = 7'h27;      // Port E bit direction
  localparam logic [6:0] ADDR_GRP_DIR = 7'h37;    // Group direction C/D

  // ----------------------------------------------------------------
  // Field positions in the group direction register
  // ----------------------------------------------------------------
  localparam int GRP_C_BIT = 2;             // Port C direction, 1 = output
  localparam int GRP_D_BIT = 3;             // Port D direction, 1 = output

  // ----------------------------------------------------------------
  // Port register data addresses and banks
  // ----------------------------------------------------------------
  localparam logic BANK0 = 1'b0;
  localparam logic BANK1 = 1'b1;
  localparam logic [6:0] ADDR_E_DATA = 7'h6f;     // Push-pull port, bank 0
  localparam logic [6:0] ADDR_KEY_DATA = 7'h70;   // Key return, bank 0
  localparam logic [6:0] ADDR_SB_DATA = 7'h70;    // Single-bit port, bank 1
  localparam logic [6:0] ADDR_B_DATA = 7'h71;     // Bit direction port
  localparam logic [6:0] ADDR_C_DATA = 7'h72;     // Group port C
  localparam logic [6:0] ADDR_D_DATA = 7'h73;     // Group port D

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_B_DIR = 4'h0;    // All inputs
  localparam logic [3:0] RST_E_DIR = 4'h0;    // All inputs
  localparam logic [3:0] RST_E_PULLUP = 4'h0; // No pull-ups
  localparam logic RST_GRP_OUT = 1'b1;        // C and D start as outputs
  localparam logic [3:0] RST_LATCH = 4'h0;    // Output latches low
  localparam logic RST_SB_LATCH = 1'b1;       // Open drain released
  localparam logic [3:0] RD_UNUSED = 4'h0;    // Answer for unused nibbles
  localparam logic [3:0] SYNC_IDLE = 4'hf;    // Synchroniser idle level

endpackage : keypad_gpio_pkg

// ---- verification/keypad_gpio_monitor.sv ----
// Assertion checker for the keypad nibble ports
`timescale 1ns/1ps

module keypad_gpio_monitor
  import keypad_gpio_pkg::*;
#(
  parameter int SINGLE_BIT_OUTPUT = 0  // 1 = single-bit port is output
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core access
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic acc_rf,
  input wire logic acc_bank,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [NIB_W-1:0] acc_wdata,
  input wire logic rd_valid,
  input wire logic mem_fwd,
  // Standby
  input wire logic standby,
  input wire logic wake,
  input wire logic [NIB_W-1:0] key_pin_in,
  // Port pins
  input wire logic [NIB_W-1:0] b_pin_out,
  input wire logic [NIB_W-1:0] b_pin_oe_b,
  input wire logic [NIB_W-1:0] b_pullup_en,
  input wire logic [NIB_W-1:0] c_pin_oe_b,
  input wire logic [NIB_W-1:0] c_pullup_en,
  input wire logic [NIB_W-1:0] d_pin_oe_b,
  input wire logic [NIB_W-1:0] d_pullup_en,
  input wire logic [NIB_W-1:0] e_pin_out,
  input wire logic [NIB_W-1:0] e_pin_oe_b,
  input wire logic [NIB_W-1:0] e_pullup_en,
  input wire logic sb_pin_out,
  input wire logic sb_pin_oe_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Access sequences
  // ----------------------------------------------------------------
  // Control space write
  sequence s_rfw(logic [6:0] a);
    acc_wr && acc_rf && acc_addr == a;
  endsequence
  // Port data write in bank 0
  sequence s_dw(logic [6:0] a);
    acc_wr && !acc_rf && !acc_bank && acc_addr == a;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rd_answer: assert property (
    acc_rd && !acc_wr |=> rd_valid ^ mem_fwd)
    else $error("read got no single answer");
  chk_no_answer: assert property (
    !(acc_rd && !acc_wr) |=> !rd_valid)
    else $error("answer without a read");
  chk_reset_dirs: assert property (
    disable iff (1'b0)
    !rst_b |=> b_pin_oe_b == 4'hf && c_pin_oe_b == 4'h0
      && d_pin_oe_b == 4'h0 && e_pin_oe_b == 4'hf && sb_pin_oe_b)
    else $error("pin drive wrong after reset");
  chk_pullup_b: assert property (
    s_rfw(ADDR_B_DIR) |=> b_pullup_en == ~$past(acc_wdata))
    else $error("port b direction not applied");
  chk_group_dir: assert property (
    s_rfw(ADDR_GRP_DIR) |=>
      c_pullup_en == {4{~$past(acc_wdata[GRP_C_BIT])}}
      && d_pullup_en == {4{~$past(acc_wdata[GRP_D_BIT])}})
    else $error("group direction not applied");
  chk_od_pullup: assert property (
    (b_pullup_en & ~b_pin_oe_b) == 4'h0 && (c_pullup_en & ~c_pin_oe_b) == 4'h0
      && (d_pullup_en & ~d_pin_oe_b) == 4'h0 && b_pin_out == 4'h0
      && !sb_pin_out)
    else $error("open drain or pull-up misuse");
  chk_e_latch: assert property (
    s_dw(ADDR_E_DATA) |=> e_pin_out == $past(acc_wdata))
    else $error("port e latch not driven");
  chk_e_pullup: assert property (
    s_rfw(ADDR_E_PULLUP) |=> e_pullup_en == $past(acc_wdata))
    else $error("port e pull-up not applied");
  chk_e_dir: assert property (
    s_rfw(ADDR_E_DIR) |=> e_pin_oe_b == ~$past(acc_wdata)
      && $stable(e_pullup_en))
    else $error("port e direction wrong");
  chk_wake_gate: assert property (!standby |=> !wake)
    else $error("wake outside standby");
  chk_wake_key: assert property (
    (standby && key_pin_in != 4'hf) [*4] |=> wake)
    else $error("key low did not wake");
  chk_sb_input: assert property (
    SINGLE_BIT_OUTPUT == 0 |-> sb_pin_oe_b)
    else $error("input single-bit port drives");
endmodule : keypad_gpio_monitor

bind keypad_gpio_ports keypad_gpio_monitor #(
  .SINGLE_BIT_OUTPUT(SINGLE_BIT_OUTPUT)
) mon_u (.clk, .rst_b, .acc_rd, .acc_wr, .acc_rf, .acc_bank, .acc_addr,
  .acc_wdata, .rd_valid, .mem_fwd, .standby, .wake, .key_pin_in,
  .b_pin_out, .b_pin_oe_b, .b_pullup_en, .c_pin_oe_b, .c_pullup_en,
  .d_pin_oe_b, .d_pullup_en, .e_pin_out, .e_pin_oe_b, .e_pullup_en,
  .sb_pin_out, .sb_pin_oe_b);

// ---- verification/port_pin_model.sv ----
// Board model of one nibble of pins: drivers, keys, pull-ups, floating
`timescale 1ns/1ps

module port_pin_model
  import keypad_gpio_pkg::*;
(
  // Clock for the floating pattern
  input wire logic clk,
  // Device side of the pins
  input wire logic [NIB_W-1:0] pin_out,
  input wire logic [NIB_W-1:0] pin_oe_b,
  input wire logic [NIB_W-1:0] pullup_en,
  // Pressed keys pull a line low
  input wire logic [NIB_W-1:0] press,
  // Resolved line levels
  output logic [NIB_W-1:0] level
);
  logic [NIB_W-1:0] float_r = 4'h5;  // Undriven lines wander each cycle

  // Floating pattern, so nothing reads a stale level
  always @(posedge clk) begin
    float_r <= ~float_r;
  end

  // Driver wins, then a key, then a pull-up, else the line floats
  always_comb begin
    for (int i = 0; i < NIB_W; i++) begin
      if (!pin_oe_b[i]) begin
        level[i] = pin_out[i];
      end else if (press[i]) begin
        level[i] = 1'b0;
      end else if (pullup_en[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = float_r[i];
      end
    end
  end
endmodule : port_pin_model

// ---- verification/tb.sv ----
// Self-checking bench for the keypad nibble ports
`timescale 1ns/1ps

`define CHK(got, exp, what) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: %s", $time, what); \
    end \
  end

module tb
  import keypad_gpio_pkg::*;
  ;
  logic clk = 1'b0, rst_b = 1'b0, standby = 1'b0;
  logic acc_rd = 1'b0, acc_wr = 1'b0, acc_rf = 1'b0, acc_bank = 1'b0;
  logic [6:0] acc_addr = 7'h00;
  logic [3:0] acc_wdata = 4'h0, rd_data;
  logic rd_valid, mem_fwd, wake, sb_pin_in, sb_pin_out, sb_pin_oe_b;
  logic [3:0] key_pin_in, b_pin_in, c_pin_in, d_pin_in, e_pin_in, sb_lvl;
  logic [3:0] b_pin_out, b_pin_oe_b, b_pullup_en, c_pin_out, c_pin_oe_b;
  logic [3:0] c_pullup_en, d_pin_out, d_pin_oe_b, d_pullup_en;
  logic [3:0] e_pin_out, e_pin_oe_b, e_pullup_en;
  logic [3:0] kp = 4'h0, bp = 4'h0, cp = 4'h0, dp = 4'h0, ep = 4'h0;
  logic sp = 1'b0;
  logic [3:0] rd1_data;
  logic sb1_oe_b;
  int n_tests = 0, n_mismatch = 0;

  always #5 clk = ~clk;

  // Device and board
  keypad_gpio_ports #(.SINGLE_BIT_OUTPUT(0)) dut_u (.clk, .rst_b, .acc_rd,
    .acc_wr, .acc_rf, .acc_bank, .acc_addr, .acc_wdata, .rd_data, .rd_valid,
    .mem_fwd, .standby, .wake, .key_pin_in, .b_pin_in, .b_pin_out,
    .b_pin_oe_b, .b_pullup_en, .c_pin_in, .c_pin_out, .c_pin_oe_b,
    .c_pullup_en, .d_pin_in, .d_pin_out, .d_pin_oe_b, .d_pullup_en,
    .e_pin_in, .e_pin_out, .e_pin_oe_b, .e_pullup_en, .sb_pin_in,
    .sb_pin_out, .sb_pin_oe_b);
  // Twin built with an output single-bit port, sharing the core bus
  keypad_gpio_ports #(.SINGLE_BIT_OUTPUT(1)) dut1_u (.clk, .rst_b, .acc_rd,
    .acc_wr, .acc_rf, .acc_bank, .acc_addr, .acc_wdata, .rd_data(rd1_data),
    .rd_valid(), .mem_fwd(), .standby, .wake(), .key_pin_in, .b_pin_in,
    .b_pin_out(), .b_pin_oe_b(), .b_pullup_en(), .c_pin_in, .c_pin_out(),
    .c_pin_oe_b(), .c_pullup_en(), .d_pin_in, .d_pin_out(), .d_pin_oe_b(),
    .d_pullup_en(), .e_pin_in, .e_pin_out(), .e_pin_oe_b(), .e_pullup_en(),
    .sb_pin_in, .sb_pin_out(), .sb_pin_oe_b(sb1_oe_b));
  port_pin_model key_m (.clk, .pin_out(4'h0), .pin_oe_b(4'hf),
    .pullup_en(4'hf), .press(kp), .level(key_pin_in));
  port_pin_model b_m (.clk, .pin_out(b_pin_out), .pin_oe_b(b_pin_oe_b),
    .pullup_en(b_pullup_en), .press(bp), .level(b_pin_in));
  port_pin_model c_m (.clk, .pin_out(c_pin_out), .pin_oe_b(c_pin_oe_b),
    .pullup_en(c_pullup_en), .press(cp), .level(c_pin_in));
  port_pin_model d_m (.clk, .pin_out(d_pin_out), .pin_oe_b(d_pin_oe_b),
    .pullup_en(d_pullup_en), .press(dp), .level(d_pin_in));
  port_pin_model e_m (.clk, .pin_out(e_pin_out), .pin_oe_b(e_pin_oe_b),
    .pullup_en(e_pullup_en), .press(ep), .level(e_pin_in));
  port_pin_model sb_m (.clk, .pin_out({3'b000, sb_pin_out}),
    .pin_oe_b({3'b111, sb_pin_oe_b}), .pullup_en(4'h0),
    .press({3'b000, sp}), .level(sb_lvl));
  assign sb_pin_in = sb_lvl[0];

  // One access; answer and pins settled on return
  task automatic acc(input logic rd, wr, rf, bank, input logic [6:0] a,
                     input logic [3:0] wd);
    @(posedge clk);
    acc_rd <= rd;
    acc_wr <= wr;
    acc_rf <= rf;
    acc_bank <= bank;
    acc_addr <= a;
    acc_wdata <= wd;
    @(posedge clk);
    acc_rd <= 1'b0;
    acc_wr <= 1'b0;
    #1;
  endtask : acc

  // Read and compare
  task automatic rdc(input logic rf, bank, input logic [6:0] a,
                     input logic [3:0] exp);
    acc(1'b1, 1'b0, rf, bank, a, 4'h0);
    `CHK(rd_valid, 1'b1, "no read answer")
    `CHK(rd_data, exp, "read value")
  endtask : rdc

  // Set key presses, then let the synchronisers settle
  task automatic pins(input logic [3:0] k, b, c, d, e, input logic s);
    @(posedge clk);
    kp <= k;
    bp <= b;
    cp <= c;
    dp <= d;
    ep <= e;
    sp <= s;
    repeat (4) @(posedge clk);
    #1;
  endtask : pins

  task automatic t_reset;
    `CHK(b_pin_oe_b, 4'hf, "b reset dir")
    `CHK(c_pin_oe_b, 4'h0, "c reset low")
    `CHK(d_pin_oe_b, 4'h0, "d reset low")
    `CHK(e_pin_oe_b, 4'hf, "e reset dir")
    `CHK(sb_pin_oe_b, 1'b1, "sb released")
    `CHK(sb1_oe_b, 1'b1, "sb out released")
    `CHK({b_pin_out, c_pin_out, d_pin_out}, 12'h000, "od data")
    rdc(1'b1, 1'b0, ADDR_B_DIR, 4'h0);
    rdc(1'b1, 1'b0, ADDR_E_DIR, 4'h0);
    rdc(1'b1, 1'b0, ADDR_GRP_DIR, 4'hc);
    rdc(1'b0, 1'b0, ADDR_C_DATA, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_key;
    pins(4'ha, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    rdc(1'b0, 1'b0, ADDR_KEY_DATA, 4'h5);
    acc(1'b0, 1'b1, 1'b0, 1'b0, ADDR_KEY_DATA, 4'h0);
    rdc(1'b0, 1'b0, ADDR_KEY_DATA, 4'h5);
    pins(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
    rdc(1'b0, 1'b1, ADDR_SB_DATA, 4'h0);
    // Output build drives low from its latch; input build never drives
    acc(1'b0, 1'b1, 1'b0, 1'b1, ADDR_SB_DATA, 4'h0);
    `CHK({sb1_oe_b, sb_pin_oe_b}, 2'b01, "sb drive")
    acc(1'b0, 1'b1, 1'b0, 1'b1, ADDR_SB_DATA, 4'h1);
    // Pin is held low, so a 1 here can only come from the latch
    acc(1'b1, 1'b0, 1'b0, 1'b1, ADDR_SB_DATA, 4'h0);
    `CHK({sb1_oe_b, rd1_data}, 5'h11, "sb latch")
    $display("test key done");
  endtask : t_key

  task automatic t_port_b;
    acc(1'b0, 1'b1, 1'b0, 1'b0, ADDR_B_DATA, 4'h6);
    `CHK(b_pin_oe_b, 4'hf, "b input drives")
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_B_DIR, 4'h3);
    `CHK(b_pin_oe_b, 4'he, "b latch not out")
    `CHK(b_pullup_en, 4'hc, "b pull-ups")
    pins(4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 1'b0);
    rdc(1'b0, 1'b0, ADDR_B_DATA, 4'h6);
    acc(1'b0, 1'b1, 1'b1, 1'b1, ADDR_B_DIR, 4'h0);
    `CHK(b_pin_oe_b, 4'hf, "bank hid control")
    $display("test port b done");
  endtask : t_port_b

  task automatic t_group;
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_GRP_DIR, 4'h8);
    `CHK(c_pullup_en, 4'hf, "c input")
    acc(1'b0, 1'b1, 1'b0, 1'b0, ADDR_C_DATA, 4'h9);
    rdc(1'b0, 1'b0, ADDR_C_DATA, 4'hf);
    acc(1'b0, 1'b1, 1'b0, 1'b0, ADDR_D_DATA, 4'h3);
    `CHK(d_pin_oe_b, 4'h3, "d latch")
    rdc(1'b0, 1'b0, ADDR_D_DATA, 4'h3);
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_GRP_DIR, 4'h4);
    `CHK(c_pin_oe_b, 4'h9, "c latch lost")
    `CHK(d_pullup_en, 4'hf, "d input")
    $display("test group done");
  endtask : t_group

  task automatic t_port_e;
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_E_PULLUP, 4'h5);
    acc(1'b0, 1'b1, 1'b0, 1'b0, ADDR_E_DATA, 4'ha);
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_E_DIR, 4'h3);
    `CHK(e_pin_oe_b, 4'hc, "e dir")
    `CHK(e_pin_out, 4'ha, "e latch")
    `CHK(e_pullup_en, 4'h5, "e pull-up")
    pins(4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 1'b0);
    rdc(1'b0, 1'b0, ADDR_E_DATA, 4'h6);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 7'h05, 4'hf);
    rdc(1'b1, 1'b0, 7'h05, RD_UNUSED);
    acc(1'b1, 1'b0, 1'b1, 1'b0, 7'h45, 4'h0);
    `CHK({mem_fwd, rd_valid}, 2'b10, "data memory")
    $display("test port e done");
  endtask : t_port_e

  task automatic t_wake;
    @(posedge clk);
    standby <= 1'b1;
    // Port E and the single-bit pin held low must not wake
    pins(4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 1'b1);
    acc(1'b0, 1'b1, 1'b1, 1'b0, ADDR_B_DIR, 4'h1);
    repeat (4) @(posedge clk);
    `CHK(wake, 1'b0, "wrong wake")
    pins(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    `CHK(wake, 1'b1, "key no wake")
    pins(4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 1'b0);
    `CHK(wake, 1'b1, "d no wake")
    @(posedge clk);
    standby <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(wake, 1'b0, "wake stuck")
    $display("test wake done");
  endtask : t_wake

  // Verdict
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_key();
    t_port_b();
    t_group();
    t_port_e();
    t_wake();
    results();
  end

  // Watchdog
  initial begin
    #50000;
    n_mismatch++;
    results();
  end
endmodule : tb
